// ==== core/cov_stencil_pkg.sv ====
// Constants, encodings and rules of the coverage and stencil stage
// How it works
// - A shader coverage output is ANDed into the fragment coverage.
// - No active shader or no coverage output leaves coverage unchanged.
// - Alpha comes from colour output zero; integer outputs skip both alpha steps.
// - Alpha-to-coverage ANDs an alpha-derived mask into coverage.
// - Set-bit count follows clamped alpha; the pattern rotates with pixel position.
// - Alpha-to-one forces fixed maximum or float 1.0, else alpha passes.
// - Order: shader mask, then alpha-to-coverage, then alpha-to-one.
// - Depth bounds pass when low <= stored depth <= high, else coverage clears.
// - Without depth attachment or with the check off, bounds always pass.
// - Bounds are static unless runtime setting is on, then latest runtime values; a load in the fragment's own cycle applies only from the next cycle.
// - Stencil compares stored value with reference and updates the stored value.
// - Stencil check off: no compare, no write, coverage untouched.
// - Two independent stencil sets, front and back, each with full parameters.
// - Stencil compare failure applies the stencil-fail action.
// - Stencil and depth pass apply pass action; depth failure applies depth-fail.
// - Only compare-mask bits take part in the stencil comparison.
// - Only write-mask bits of the stored stencil value are modified.
// - Separate controls for depth check, depth writes and depth compare function.
// - Compare functions 0..7 with masked reference left, masked stored right.
// - Reference clamps to stencil range; both operands ANDed with compare mask.
// - Update actions 0..7: keep, zero, replace, sat inc, sat dec, invert, wrap inc, wrap dec.
// - Depth and stencil work only on samples whose coverage bit is set.
package cov_stencil_pkg;
    localparam int SAMPLES = 4;
    localparam int STENCIL_W = 8;
    localparam int DEPTH_W = 16;
    localparam int ALPHA_W = 16;
    localparam int FACES = 2;
    localparam int FACE_FRONT = 0;
    localparam int FACE_BACK = 1;
    // Comparison function encodings
    localparam logic [2:0] CMP_NEVER = 3'h0;
    localparam logic [2:0] CMP_LESS = 3'h1;
    localparam logic [2:0] CMP_EQUAL = 3'h2;
    localparam logic [2:0] CMP_LEQUAL = 3'h3;
    localparam logic [2:0] CMP_GREATER = 3'h4;
    localparam logic [2:0] CMP_NOTEQUAL = 3'h5;
    localparam logic [2:0] CMP_GEQUAL = 3'h6;
    localparam logic [2:0] CMP_ALWAYS = 3'h7;
    // Stencil update action encodings
    localparam logic [2:0] ACT_KEEP = 3'h0;
    localparam logic [2:0] ACT_ZERO = 3'h1;
    localparam logic [2:0] ACT_REPLACE = 3'h2;
    localparam logic [2:0] ACT_INC_SAT = 3'h3;
    localparam logic [2:0] ACT_DEC_SAT = 3'h4;
    localparam logic [2:0] ACT_INVERT = 3'h5;
    localparam logic [2:0] ACT_INC_WRAP = 3'h6;
    localparam logic [2:0] ACT_DEC_WRAP = 3'h7;
    // Stencil range and alpha forms
    localparam logic [STENCIL_W-1:0] STENCIL_MAX = 8'hff;
    localparam logic [ALPHA_W-1:0] ALPHA_FIXED_MAX = 16'hffff;
    localparam logic [ALPHA_W-1:0] ALPHA_FLOAT_ONE = 16'h3c00;
    localparam logic [4:0] HALF_EXP_BIAS = 5'h0f;
    localparam logic [SAMPLES-1:0] COV_ALL = 4'hf;
endpackage : cov_stencil_pkg

// ==== core/alpha_coverage_unit.sv ====
// Shader coverage mask, alpha-to-coverage and alpha-to-one, combinational
`timescale 1ns/1ps
module alpha_coverage_unit (
    input wire logic [cov_stencil_pkg::SAMPLES-1:0] coverage_in,
    input wire logic shader_active_in,
    input wire logic shader_has_mask_in,
    input wire logic shader_mask_written_in,
    input wire logic [cov_stencil_pkg::SAMPLES-1:0] shader_coverage_out_in,
    input wire logic [cov_stencil_pkg::ALPHA_W-1:0] alpha_in,
    input wire logic alpha_integer_in,
    input wire logic target_float_in,
    input wire logic alpha_derived_mask_on_in,
    input wire logic alpha_force_max_on_in,
    input wire logic [1:0] pixel_x_in,
    input wire logic [1:0] pixel_y_in,
    output logic [cov_stencil_pkg::SAMPLES-1:0] coverage_out,
    output logic [cov_stencil_pkg::ALPHA_W-1:0] alpha_out
);
    import cov_stencil_pkg::*;

    logic [SAMPLES-1:0] shader_cov;
    logic [SAMPLES-1:0] ones_mask;
    logic [SAMPLES-1:0] alpha_mask;
    logic [2:0] level;
    logic [10:0] frac;
    logic [12:0] scaled;
    logic [1:0] rot;

    // Shader mask first; an unwritten mask ANDs all ones, so runs repeat
    always_comb begin
        shader_cov = coverage_in;
        if (shader_active_in && shader_has_mask_in) begin
            shader_cov = coverage_in & (shader_mask_written_in ? shader_coverage_out_in : COV_ALL);
        end
    end

    // Alpha to a 0..4 sample count, clamped to the unit range
    always_comb begin
        frac = 11'h000;
        scaled = 13'h0000;
        level = 3'h0;
        if (target_float_in) begin
            if (alpha_in[15] || alpha_in[14:10] == 5'h00) begin
                level = 3'h0; // Negative and tiny values count as zero
            end else if (alpha_in[14:10] >= HALF_EXP_BIAS) begin
                level = 3'h4;
            end else begin
                frac = {1'b1, alpha_in[9:0]} >> (HALF_EXP_BIAS - alpha_in[14:10]);
                scaled = {frac, 2'b00} + 13'h0200;
                level = 3'(scaled[12:10]);
            end
        end else begin
            scaled = 13'({alpha_in[15:8], 2'b00} + 10'h080);
            level = 3'(scaled[10:8]);
            if (alpha_in == ALPHA_FIXED_MAX) begin
                level = 3'h4;
            end
        end
    end

    // Rotating by pixel spreads partial masks across neighbours
    always_comb begin
        ones_mask = SAMPLES'((5'h01 << level) - 5'h01);
        rot = pixel_x_in + pixel_y_in;
        alpha_mask = SAMPLES'({ones_mask, ones_mask} >> rot);
    end

    // Alpha steps follow the shader mask and are skipped for integer outputs
    always_comb begin
        coverage_out = shader_cov;
        alpha_out = alpha_in;
        if (!alpha_integer_in) begin
            if (alpha_derived_mask_on_in) begin
                coverage_out = shader_cov & alpha_mask;
            end
            if (alpha_force_max_on_in) begin
                alpha_out = target_float_in ? ALPHA_FLOAT_ONE : ALPHA_FIXED_MAX;
            end
        end
    end
endmodule : alpha_coverage_unit

// ==== core/stencil_sample_unit.sv ====
// Stencil compare and update for one sample, combinational
`timescale 1ns/1ps
module stencil_sample_unit (
    input wire logic covered_in,
    input wire logic stencil_check_on_in,
    input wire logic [cov_stencil_pkg::STENCIL_W-1:0] stored_in,
    input wire logic [cov_stencil_pkg::STENCIL_W-1:0] reference_in,
    input wire logic [cov_stencil_pkg::STENCIL_W-1:0] select_bits_in,
    input wire logic [cov_stencil_pkg::STENCIL_W-1:0] update_bits_in,
    input wire logic [2:0] compare_func_in,
    input wire logic [2:0] fail_action_in,
    input wire logic [2:0] pass_action_in,
    input wire logic [2:0] zfail_action_in,
    input wire logic z_pass_in,
    output logic covered_out,
    output logic write_out,
    output logic [cov_stencil_pkg::STENCIL_W-1:0] data_out
);
    import cov_stencil_pkg::*;

    logic [STENCIL_W-1:0] ref_m;
    logic [STENCIL_W-1:0] st_m;
    logic pass;
    logic [2:0] action;
    logic [STENCIL_W-1:0] updated;

    // Masked compare, reference on the left
    always_comb begin
        ref_m = reference_in & select_bits_in;
        st_m = stored_in & select_bits_in;
        case (compare_func_in)
            CMP_NEVER: pass = 1'b0;
            CMP_LESS: pass = ref_m < st_m;
            CMP_EQUAL: pass = ref_m == st_m;
            CMP_LEQUAL: pass = ref_m <= st_m;
            CMP_GREATER: pass = ref_m > st_m;
            CMP_NOTEQUAL: pass = ref_m != st_m;
            CMP_GEQUAL: pass = ref_m >= st_m;
            default: pass = 1'b1;
        endcase
    end

    // Action choice and its effect on the stored value
    always_comb begin
        action = !pass ? fail_action_in : (z_pass_in ? pass_action_in : zfail_action_in);
        case (action)
            ACT_KEEP: updated = stored_in;
            ACT_ZERO: updated = '0;
            ACT_REPLACE: updated = reference_in;
            ACT_INC_SAT: updated = (stored_in == STENCIL_MAX) ? stored_in : stored_in + 8'h01;
            ACT_DEC_SAT: updated = (stored_in == '0) ? stored_in : stored_in - 8'h01;
            ACT_INVERT: updated = ~stored_in;
            ACT_INC_WRAP: updated = stored_in + 8'h01;
            default: updated = stored_in - 8'h01;
        endcase
    end

    // Uncovered samples and a disabled check change nothing
    always_comb begin
        covered_out = covered_in;
        write_out = 1'b0;
        data_out = stored_in;
        if (covered_in && stencil_check_on_in) begin
            covered_out = pass;
            write_out = 1'b1;
            data_out = (stored_in & ~update_bits_in) | (updated & update_bits_in);
        end
    end
endmodule : stencil_sample_unit

// ==== core/coverage_stencil_front.sv ====
// Per-sample coverage, depth bounds and stencil front end, one registered stage
`timescale 1ns/1ps
module coverage_stencil_front (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic frag_valid_in,
    input wire logic [cov_stencil_pkg::SAMPLES-1:0] frag_coverage_in,
    input wire logic shader_active_in,
    input wire logic shader_has_mask_in,
    input wire logic shader_mask_written_in,
    input wire logic [cov_stencil_pkg::SAMPLES-1:0] shader_coverage_out_in,
    input wire logic [cov_stencil_pkg::ALPHA_W-1:0] alpha_in,
    input wire logic alpha_integer_in,
    input wire logic target_float_in,
    input wire logic [1:0] pixel_x_in,
    input wire logic [1:0] pixel_y_in,
    input wire logic polygon_in,
    input wire logic back_facing_in,
    input wire logic alpha_derived_mask_on_in,
    input wire logic alpha_force_max_on_in,
    input wire logic z_check_on_in,
    input wire logic z_store_on_in,
    input wire logic [2:0] z_compare_func_in,
    input wire logic depth_attached_in,
    input wire logic z_range_check_on_in,
    input wire logic [cov_stencil_pkg::DEPTH_W-1:0] z_range_low_in,
    input wire logic [cov_stencil_pkg::DEPTH_W-1:0] z_range_high_in,
    input wire logic z_range_runtime_set_in,
    input wire logic runtime_load_in,
    input wire logic [cov_stencil_pkg::DEPTH_W-1:0] runtime_low_in,
    input wire logic [cov_stencil_pkg::DEPTH_W-1:0] runtime_high_in,
    input wire logic stencil_check_on_in,
    input wire logic [cov_stencil_pkg::FACES-1:0][2:0] stencil_fail_action_in,
    input wire logic [cov_stencil_pkg::FACES-1:0][2:0] both_pass_action_in,
    input wire logic [cov_stencil_pkg::FACES-1:0][2:0] z_fail_action_in,
    input wire logic [cov_stencil_pkg::FACES-1:0][2:0] stencil_compare_func_in,
    input wire logic [cov_stencil_pkg::FACES-1:0][31:0] stencil_select_bits_in,
    input wire logic [cov_stencil_pkg::FACES-1:0][31:0] stencil_update_bits_in,
    input wire logic [cov_stencil_pkg::FACES-1:0][31:0] stencil_reference_in,
    input wire logic [cov_stencil_pkg::SAMPLES-1:0][cov_stencil_pkg::DEPTH_W-1:0] stored_depth_in,
    input wire logic [cov_stencil_pkg::SAMPLES-1:0][cov_stencil_pkg::STENCIL_W-1:0] stored_stencil_in,
    input wire logic [cov_stencil_pkg::SAMPLES-1:0] z_pass_in,
    output logic frag_valid_out,
    output logic [cov_stencil_pkg::SAMPLES-1:0] coverage_out,
    output logic frag_killed_out,
    output logic [cov_stencil_pkg::ALPHA_W-1:0] alpha_out,
    output logic [cov_stencil_pkg::SAMPLES-1:0] stencil_write_out,
    output logic [cov_stencil_pkg::SAMPLES-1:0][cov_stencil_pkg::STENCIL_W-1:0] stencil_data_out,
    output logic z_check_on_out,
    output logic z_store_on_out,
    output logic [2:0] z_compare_func_out
);
    import cov_stencil_pkg::*;

    typedef struct packed {
        logic valid;
        logic [SAMPLES-1:0] cov;
        logic killed;
        logic [ALPHA_W-1:0] alpha;
        logic [SAMPLES-1:0] swr;
        logic [SAMPLES-1:0][STENCIL_W-1:0] sdata;
        logic zon;
        logic zst;
        logic [2:0] zfunc;
        logic [DEPTH_W-1:0] rt_low;
        logic [DEPTH_W-1:0] rt_high;
    } state_type;

    state_type state_r;
    state_type state_nxt;

    logic [SAMPLES-1:0] ms_cov;
    logic [ALPHA_W-1:0] ms_alpha;
    logic [SAMPLES-1:0] bounds_cov;
    logic [SAMPLES-1:0] st_cov;
    logic [SAMPLES-1:0] st_wr;
    logic [SAMPLES-1:0][STENCIL_W-1:0] st_data;
    logic [DEPTH_W-1:0] low_used;
    logic [DEPTH_W-1:0] high_used;
    logic face;
    logic [STENCIL_W-1:0] ref_clamped;
    logic [SAMPLES-1:0] z_ok;

    // Multisample coverage and alpha steps
    alpha_coverage_unit u_alpha (
        .coverage_in(frag_coverage_in),
        .shader_active_in(shader_active_in),
        .shader_has_mask_in(shader_has_mask_in),
        .shader_mask_written_in(shader_mask_written_in),
        .shader_coverage_out_in(shader_coverage_out_in),
        .alpha_in(alpha_in),
        .alpha_integer_in(alpha_integer_in),
        .target_float_in(target_float_in),
        .alpha_derived_mask_on_in(alpha_derived_mask_on_in),
        .alpha_force_max_on_in(alpha_force_max_on_in),
        .pixel_x_in(pixel_x_in),
        .pixel_y_in(pixel_y_in),
        .coverage_out(ms_cov),
        .alpha_out(ms_alpha)
    );

    // Bound source and stencil face selection
    always_comb begin
        low_used = z_range_runtime_set_in ? state_r.rt_low : z_range_low_in;
        high_used = z_range_runtime_set_in ? state_r.rt_high : z_range_high_in;
        face = polygon_in && back_facing_in;
        ref_clamped = (stencil_reference_in[face] > 32'(STENCIL_MAX)) ? STENCIL_MAX
            : stencil_reference_in[face][STENCIL_W-1:0];
    end

    // Per-sample bounds then stencil; depth passes when its check is off
    for (genvar s = 0; s < SAMPLES; s++) begin : g_sample
        always_comb begin
            bounds_cov[s] = ms_cov[s];
            if (ms_cov[s] && depth_attached_in && z_range_check_on_in) begin
                bounds_cov[s] = (stored_depth_in[s] >= low_used) && (stored_depth_in[s] <= high_used);
            end
            z_ok[s] = !z_check_on_in || z_pass_in[s];
        end

        stencil_sample_unit u_stencil (
            .covered_in(bounds_cov[s]),
            .stencil_check_on_in(stencil_check_on_in),
            .stored_in(stored_stencil_in[s]),
            .reference_in(ref_clamped),
            .select_bits_in(stencil_select_bits_in[face][STENCIL_W-1:0]),
            .update_bits_in(stencil_update_bits_in[face][STENCIL_W-1:0]),
            .compare_func_in(stencil_compare_func_in[face]),
            .fail_action_in(stencil_fail_action_in[face]),
            .pass_action_in(both_pass_action_in[face]),
            .zfail_action_in(z_fail_action_in[face]),
            .z_pass_in(z_ok[s]),
            .covered_out(st_cov[s]),
            .write_out(st_wr[s]),
            .data_out(st_data[s])
        );
    end

    // Next state: results register one cycle after a fragment
    always_comb begin
        state_nxt = state_r;
        state_nxt.valid = frag_valid_in;
        state_nxt.swr = '0;
        if (frag_valid_in) begin
            state_nxt.cov = st_cov;
            state_nxt.killed = (st_cov == '0);
            state_nxt.alpha = ms_alpha;
            state_nxt.swr = st_wr;
            state_nxt.sdata = st_data;
            state_nxt.zon = z_check_on_in;
            state_nxt.zst = z_store_on_in;
            state_nxt.zfunc = z_compare_func_in;
        end
        // Runtime bounds always track the latest load, even between fragments
        if (runtime_load_in) begin
            state_nxt.rt_low = runtime_low_in;
            state_nxt.rt_high = runtime_high_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs straight from the state register
    assign frag_valid_out = state_r.valid;
    assign coverage_out = state_r.cov;
    assign frag_killed_out = state_r.killed;
    assign alpha_out = state_r.alpha;
    assign stencil_write_out = state_r.swr;
    assign stencil_data_out = state_r.sdata;
    assign z_check_on_out = state_r.zon;
    assign z_store_on_out = state_r.zst;
    assign z_compare_func_out = state_r.zfunc;

    // Checks
    chk_cov_subset: assert property (@(posedge clk_in) disable iff (rst_in)
        frag_valid_in |=> (coverage_out & ~$past(frag_coverage_in)) == '0)
        else $error("coverage grew");

    chk_shader_and: assert property (@(posedge clk_in) disable iff (rst_in)
        frag_valid_in && shader_active_in && shader_has_mask_in && shader_mask_written_in
        |=> (coverage_out & ~$past(shader_coverage_out_in)) == '0)
        else $error("shader coverage mask not applied");

    chk_int_alpha: assert property (@(posedge clk_in) disable iff (rst_in)
        frag_valid_in && alpha_integer_in |=> alpha_out == $past(alpha_in))
        else $error("integer alpha modified");

    chk_force_fixed: assert property (@(posedge clk_in) disable iff (rst_in)
        frag_valid_in && alpha_force_max_on_in && !alpha_integer_in && !target_float_in
        |=> alpha_out == ALPHA_FIXED_MAX)
        else $error("fixed alpha not forced");

    chk_stencil_off: assert property (@(posedge clk_in) disable iff (rst_in)
        frag_valid_in && !stencil_check_on_in && !z_range_check_on_in
        |=> stencil_write_out == '0 && coverage_out == $past(ms_cov))
        else $error("disabled stencil acted");

    chk_skip_uncov: assert property (@(posedge clk_in) disable iff (rst_in)
        frag_valid_in |=> (stencil_write_out & ~$past(frag_coverage_in)) == '0)
        else $error("uncovered sample written");

    chk_bounds_off: assert property (@(posedge clk_in) disable iff (rst_in)
        frag_valid_in && !depth_attached_in && !stencil_check_on_in |=> coverage_out == $past(ms_cov))
        else $error("bounds check acted unattached");

    chk_runtime_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        runtime_load_in ##1 !runtime_load_in [*2] |-> state_r.rt_low == $past(runtime_low_in, 2))
        else $error("runtime lower bound not held");

    chk_z_ctrl: assert property (@(posedge clk_in) disable iff (rst_in)
        frag_valid_in |=> z_store_on_out == $past(z_store_on_in) && z_compare_func_out == $past(z_compare_func_in))
        else $error("depth controls lost");

    chk_killed_flag: assert property (@(posedge clk_in) disable iff (rst_in)
        frag_valid_out |-> frag_killed_out == (coverage_out == '0))
        else $error("kill flag wrong");

    for (genvar k = 0; k < SAMPLES; k++) begin : g_chk
        chk_write_mask: assert property (@(posedge clk_in) disable iff (rst_in)
            frag_valid_in && st_wr[k] |=> ((stencil_data_out[k] ^ $past(stored_stencil_in[k]))
            & ~$past(stencil_update_bits_in[face][STENCIL_W-1:0])) == '0)
            else $error("bits outside write mask changed");
    end
endmodule : coverage_stencil_front

// ==== verif/stencil_store_model.sv ====
// Attachment model: stored stencil of one pixel
`timescale 1ns/1ps
module stencil_store_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic valid_in,
    input wire logic [3:0] write_in,
    input wire logic [3:0][7:0] data_in,
    output logic [3:0][7:0] stored_out
);
    import cov_stencil_pkg::*;
    // Merged write-back; start values sit at and one step inside both saturation ends
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stored_out <= {8'hfe, 8'h01, 8'hff, 8'h00};
        end else if (valid_in) begin
            for (int s = 0; s < SAMPLES; s++) begin
                if (write_in[s]) stored_out[s] <= data_in[s];
            end
        end
    end
endmodule : stencil_store_model

// ==== verif/coverage_stencil_front_tb_top.sv ====
// Random and corner-case bench of the coverage stencil stage
`timescale 1ns/1ps
module coverage_stencil_front_tb_top;
    import cov_stencil_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic frag_valid_in, shader_active_in, shader_has_mask_in, shader_mask_written_in, alpha_integer_in;
    logic target_float_in, polygon_in, back_facing_in, alpha_derived_mask_on_in, alpha_force_max_on_in;
    logic z_check_on_in, z_store_on_in, depth_attached_in, z_range_check_on_in, z_range_runtime_set_in;
    logic runtime_load_in, stencil_check_on_in, frag_valid_out, frag_killed_out, z_check_on_out, z_store_on_out;
    logic [3:0] frag_coverage_in, shader_coverage_out_in, z_pass_in, coverage_out, stencil_write_out, e_cov, e_wr;
    logic [1:0] pixel_x_in, pixel_y_in;
    logic [2:0] z_compare_func_in, z_compare_func_out;
    logic [15:0] alpha_in, alpha_out, z_range_low_in, z_range_high_in, runtime_low_in, runtime_high_in;
    logic [15:0] e_alpha, rt_lo, rt_hi;
    logic [1:0][2:0] stencil_fail_action_in, both_pass_action_in, z_fail_action_in, stencil_compare_func_in;
    logic [1:0][31:0] stencil_select_bits_in, stencil_update_bits_in, stencil_reference_in;
    logic [3:0][15:0] stored_depth_in;
    logic [3:0][7:0] stored_stencil_in, stencil_data_out, e_data;
    logic [4:0] e_z;
    logic e_valid = 1'b0;
    int seed = 83, miscompares = 0, comparisons = 0;
    coverage_stencil_front u_coverage_stencil_front (.clk_in, .rst_in, .frag_valid_in, .frag_coverage_in,
        .shader_active_in, .shader_has_mask_in, .shader_mask_written_in, .shader_coverage_out_in, .alpha_in,
        .alpha_integer_in, .target_float_in, .pixel_x_in, .pixel_y_in, .polygon_in, .back_facing_in,
        .alpha_derived_mask_on_in, .alpha_force_max_on_in, .z_check_on_in, .z_store_on_in, .z_compare_func_in,
        .depth_attached_in, .z_range_check_on_in, .z_range_low_in, .z_range_high_in, .z_range_runtime_set_in,
        .runtime_load_in, .runtime_low_in, .runtime_high_in, .stencil_check_on_in, .stencil_fail_action_in,
        .both_pass_action_in, .z_fail_action_in, .stencil_compare_func_in, .stencil_select_bits_in,
        .stencil_update_bits_in, .stencil_reference_in, .stored_depth_in, .stored_stencil_in, .z_pass_in,
        .frag_valid_out, .coverage_out, .frag_killed_out, .alpha_out, .stencil_write_out, .stencil_data_out,
        .z_check_on_out, .z_store_on_out, .z_compare_func_out);
    stencil_store_model u_stencil_store_model (.clk_in, .rst_in, .valid_in(frag_valid_out),
        .write_in(stencil_write_out), .data_in(stencil_data_out), .stored_out(stored_stencil_in));
    // 10 MHz clock
    always #50 clk_in = ~clk_in;
    function automatic logic [7:0] act(input logic [2:0] a, input logic [7:0] s, input logic [7:0] r);
        case (a)
            ACT_KEEP: return s;
            ACT_ZERO: return 8'h00;
            ACT_REPLACE: return r;
            ACT_INC_SAT: return (s == STENCIL_MAX) ? s : s + 8'h01;
            ACT_DEC_SAT: return (s == 8'h00) ? s : s - 8'h01;
            ACT_INVERT: return ~s;
            ACT_INC_WRAP: return s + 8'h01;
            default: return s - 8'h01;
        endcase
    endfunction : act
    function automatic logic cmp(input logic [2:0] f, input logic [7:0] r, input logic [7:0] s);
        case (f)
            CMP_NEVER: return 1'b0;
            CMP_LESS: return r < s;
            CMP_EQUAL: return r == s;
            CMP_LEQUAL: return r <= s;
            CMP_GREATER: return r > s;
            CMP_NOTEQUAL: return r != s;
            CMP_GEQUAL: return r >= s;
            default: return 1'b1;
        endcase
    endfunction : cmp
    // Expected outputs, seen one edge later
    task automatic predict();
        logic [7:0] r, m, w, st, nv;
        logic [15:0] lo, hi;
        int f;
        logic ok;
        e_valid = frag_valid_in;
        if (!frag_valid_in) return;
        e_cov = frag_coverage_in;
        if (shader_active_in && shader_has_mask_in) e_cov &= shader_mask_written_in ? shader_coverage_out_in : COV_ALL;
        if (!alpha_integer_in && alpha_derived_mask_on_in && alpha_in == 16'h0000) e_cov = 4'h0;
        e_alpha = (!alpha_integer_in && alpha_force_max_on_in) ?
            (target_float_in ? ALPHA_FLOAT_ONE : ALPHA_FIXED_MAX) : alpha_in;
        e_z = {z_check_on_in, z_store_on_in, z_compare_func_in};
        f = (polygon_in && back_facing_in) ? FACE_BACK : FACE_FRONT;
        r = (stencil_reference_in[f] > 32'hff) ? STENCIL_MAX : stencil_reference_in[f][7:0];
        m = stencil_select_bits_in[f][7:0];
        w = stencil_update_bits_in[f][7:0];
        lo = z_range_runtime_set_in ? rt_lo : z_range_low_in;
        hi = z_range_runtime_set_in ? rt_hi : z_range_high_in;
        e_wr = 4'h0;
        for (int s = 0; s < SAMPLES; s++) begin
            st = stored_stencil_in[s];
            if (depth_attached_in && z_range_check_on_in && (stored_depth_in[s] < lo || stored_depth_in[s] > hi)) begin
                e_cov[s] = 1'b0;
            end else if (e_cov[s] && stencil_check_on_in) begin
                ok = cmp(stencil_compare_func_in[f], r & m, st & m);
                nv = act(z_fail_action_in[f], st, r);
                if (!z_check_on_in || z_pass_in[s]) nv = act(both_pass_action_in[f], st, r);
                if (!ok) nv = act(stencil_fail_action_in[f], st, r);
                e_cov[s] = ok;
                e_wr[s] = 1'b1;
                e_data[s] = (st & ~w) | (nv & w);
            end
        end
    endtask : predict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic check_out();
        chk(frag_valid_out, e_valid);
        chk(stencil_write_out, e_valid ? e_wr : 4'h0);
        if (e_valid) begin
            chk(coverage_out, e_cov);
            chk(frag_killed_out, e_cov == 4'h0);
            chk(alpha_out, e_alpha);
            chk({z_check_on_out, z_store_on_out, z_compare_func_out}, e_z);
            for (int s = 0; s < SAMPLES; s++) begin
                if (e_wr[s]) chk(stencil_data_out[s], e_data[s]);
            end
        end
    endtask : check_out
    // Bounds are unorm so in range; range check needs capability
    task automatic drive(input bit live);
        logic cap;
        cap = 1'($random(seed));
        {shader_active_in, shader_has_mask_in, shader_mask_written_in, alpha_integer_in, target_float_in, polygon_in,
            back_facing_in, alpha_derived_mask_on_in, alpha_force_max_on_in, z_check_on_in, z_store_on_in,
            depth_attached_in, z_range_runtime_set_in, runtime_load_in, stencil_check_on_in} = 15'($random(seed));
        frag_valid_in = live && (($random(seed) & 3) != 0);
        z_range_check_on_in = cap & 1'($random(seed));
        {frag_coverage_in, shader_coverage_out_in, z_pass_in, pixel_x_in, pixel_y_in, z_compare_func_in} = 19'($random(seed));
        alpha_in = 16'($random(seed));
        if (alpha_derived_mask_on_in) alpha_in = alpha_in[0] ? (target_float_in ? ALPHA_FLOAT_ONE : ALPHA_FIXED_MAX) : 16'h0000;
        {z_range_low_in, z_range_high_in} = $random(seed);
        {runtime_low_in, runtime_high_in} = $random(seed);
        {stencil_fail_action_in, both_pass_action_in, z_fail_action_in, stencil_compare_func_in} = 24'($random(seed));
        stencil_select_bits_in = {$random(seed), $random(seed)};
        stencil_update_bits_in = {$random(seed), $random(seed)};
        stencil_reference_in = {$random(seed), 24'h000000, 8'($random(seed))};
        stored_depth_in = {$random(seed), $random(seed)};
    endtask : drive
    task automatic tally_and_finish();
        $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    // First eight cycles drive codes 0..7 on both faces, with the fragment valid at random
    initial begin
        {rt_lo, rt_hi} = 32'h0;
        drive(1'b0);
        repeat (6) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 1'b0;
        runtime_load_in = 1'b0;
        for (int i = 0; i < 601; i++) begin
            @(negedge clk_in);
            check_out();
            drive(i < 600);
            if (i < 8) {stencil_fail_action_in, both_pass_action_in, z_fail_action_in, stencil_compare_func_in} = {8{3'(i)}};
            predict();
            if (runtime_load_in) {rt_lo, rt_hi} = {runtime_low_in, runtime_high_in};
        end
        tally_and_finish();
    end
    // Watchdog at about three run lengths
    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end
endmodule : coverage_stencil_front_tb_top
